// ==== rtl/inval_queue_pkg.sv ====
/*
  Shared constants for the invalidation queue register bank: register
  offsets, field positions, reset values and bus widths.
  Assumes a 32-bit Avalon-MM register bus with byte addresses.
*/
package inval_queue_pkg;
  // Bus shape
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // Register byte offsets, each 32-bit word on its own address
  localparam logic [7:0] TAIL_LO_OFF = 8'h88;
  localparam logic [7:0] TAIL_HI_OFF = 8'h8c;
  localparam logic [7:0] ADDR_LO_OFF = 8'h90;
  localparam logic [7:0] ADDR_HI_OFF = 8'h94;
  localparam logic [7:0] STATUS_OFF = 8'h9c;
  localparam logic [7:0] HEAD_LO_OFF = 8'h80;
  localparam logic [7:0] HEAD_HI_OFF = 8'h84;
  localparam logic [7:0] CTRL_OFF = 8'hc0;
  // Field positions
  localparam int OFFSET_LSB = 4;
  localparam int OFFSET_MSB = 18;
  localparam int OFFSET_W = 15;
  localparam int BASE_LSB = 12;
  localparam int BASE_W = 52;
  localparam int SIZE_W = 3;
  localparam int ENTRY_SHIFT = 8;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_CAP_BIT = 1;
  // Reset values
  localparam logic [14:0] OFFSET_RST = 15'h0000;
  localparam logic [51:0] BASE_RST = 52'h0_0000_0000_0000;
  localparam logic [2:0] SIZE_RST = 3'h0;
  localparam logic WAIT_DONE_RST = 1'b0;
  // Default host address width
  localparam int HOST_ADDR_WIDTH = 48;
endpackage

// ==== rtl/inval_queue_regs.sv ====
/*
  Invalidation queue register bank: tail, queue address, completion status,
  plus a read-only head view and a control word, on Avalon-MM.
  Assumes a 32-bit Avalon-MM master on sys_clk_in and a fetch engine on the
  same clock that pulses fetch and wait-done strobes.
*/
`timescale 1ns/10ps
`default_nettype none
module inval_queue_regs (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Capability strap and fetch engine
  input wire logic qi_supported_in,
  input wire logic fetch_in,
  input wire logic wait_done_in,
  // Queue state to fetch engine
  output logic [63:0] queue_base_out,
  output logic [2:0] queue_size_log2_out,
  output logic [14:0] head_offset_out,
  output logic queue_empty_out,
  output logic event_pending_out
);
  logic [14:0] tail_offset_reg;
  logic [51:0] queue_base_reg;
  logic [2:0] queue_size_reg;
  logic enable_reg;
  logic cap_reg;
  logic ack_reg;
  logic waitreq_reg;
  logic [31:0] rdata_reg;
  logic [63:0] base_out_reg;
  logic [2:0] size_out_reg;
  logic [14:0] head_out_reg;
  logic empty_reg;
  logic pend_reg;
  logic [31:0] rdata_next;
  logic [31:0] wmask;
  logic wr_go;
  logic rd_go;
  logic clr_wait;
  logic flag;
  logic new_event;
  logic [63:0] base_mask;
  logic [63:0] base_full;

  queue_ptr_if ptr_bus ();

  // Capability caught by a clocked process each cycle
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      cap_reg <= 1'b0;
    end else begin
      cap_reg <= qi_supported_in;
    end
  end

  // One wait state: request taken at first edge, answered at the next
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (avs_read || avs_write) && !ack_reg;
    end
  end

  // Waitrequest from its own flop, low in the answer cycle only
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      waitreq_reg <= 1'b1;
    end else begin
      waitreq_reg <= !((avs_read || avs_write) && !ack_reg);
    end
  end

  // Access strobes and byte mask
  always_comb begin
    wr_go = avs_write && ack_reg;
    rd_go = avs_read && !ack_reg;
    for (int i = 0; i < 4; i++) begin
      wmask[i*8 +: 8] = {8{avs_byteenable[i]}};
    end
    base_mask = (64'h0000_0000_0000_0001 << inval_queue_pkg::HOST_ADDR_WIDTH)
      - 64'h0000_0000_0000_0001;
  end

  // Tail offset register
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      tail_offset_reg <= inval_queue_pkg::OFFSET_RST;
    end else if (wr_go && cap_reg && avs_address == inval_queue_pkg::TAIL_LO_OFF) begin
      tail_offset_reg <= (tail_offset_reg & ~wmask[18:4])
        | (avs_writedata[18:4] & wmask[18:4]);
    end
  end

  // Queue base and size register
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      queue_base_reg <= inval_queue_pkg::BASE_RST;
      queue_size_reg <= inval_queue_pkg::SIZE_RST;
    end else if (wr_go && cap_reg) begin
      if (avs_address == inval_queue_pkg::ADDR_LO_OFF) begin
        queue_base_reg[19:0] <= (queue_base_reg[19:0] & ~wmask[31:12])
          | (avs_writedata[31:12] & wmask[31:12]);
        queue_size_reg <= (queue_size_reg & ~wmask[2:0])
          | (avs_writedata[2:0] & wmask[2:0]);
      end else if (avs_address == inval_queue_pkg::ADDR_HI_OFF) begin
        queue_base_reg[51:20] <= ((queue_base_reg[51:20] & ~wmask)
          | (avs_writedata & wmask)) & base_mask[63:32];
      end
    end
  end

  // Control word: queued invalidation enable
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      enable_reg <= 1'b0;
    end else if (wr_go && avs_address == inval_queue_pkg::CTRL_OFF && avs_byteenable[0]) begin
      enable_reg <= avs_writedata[inval_queue_pkg::CTRL_ENABLE_BIT];
    end
  end

  // Write-one-to-clear on the status word
  always_comb begin
    clr_wait = wr_go && cap_reg && avs_address == inval_queue_pkg::STATUS_OFF
      && avs_byteenable[0] && avs_writedata[0];
  end

  wait_done_flag_cell flag_cell (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .set_in(wait_done_in && cap_reg),
    .clear_in(clr_wait),
    .flag_out(flag),
    .new_event_out(new_event)
  );

  // Pointer carrier wiring
  assign ptr_bus.size_log2 = queue_size_reg;
  assign ptr_bus.tail_offset = tail_offset_reg;
  assign ptr_bus.enable = enable_reg && cap_reg;
  assign ptr_bus.advance = fetch_in;

  queue_head_ptr head_ptr (
    .sys_clk_in(sys_clk_in),
    .sys_rst_in(sys_rst_in),
    .p(ptr_bus)
  );

  // Read mux, unsupported feature reads zero except the control word, which still shows the enable bit
  always_comb begin
    base_full = {queue_base_reg, 12'h000};
    rdata_next = 32'h0000_0000;
    unique case (avs_address)
      inval_queue_pkg::TAIL_LO_OFF: rdata_next[18:4] = tail_offset_reg;
      inval_queue_pkg::ADDR_LO_OFF: rdata_next = {base_full[31:12], 9'h000, queue_size_reg};
      inval_queue_pkg::ADDR_HI_OFF: rdata_next = base_full[63:32];
      inval_queue_pkg::STATUS_OFF: rdata_next[0] = flag;
      inval_queue_pkg::HEAD_LO_OFF: rdata_next[18:4] = ptr_bus.head_offset;
      inval_queue_pkg::CTRL_OFF: rdata_next = {30'h0000_0000, cap_reg, enable_reg};
      default: rdata_next = 32'h0000_0000;
    endcase
    if (!cap_reg && avs_address != inval_queue_pkg::CTRL_OFF) begin
      rdata_next = 32'h0000_0000;
    end
  end

  // Read data captured when the request is taken
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      rdata_reg <= 32'h0000_0000;
    end else if (rd_go) begin
      rdata_reg <= rdata_next;
    end
  end

  // Registered queue state and event outputs
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      base_out_reg <= 64'h0000_0000_0000_0000;
      size_out_reg <= inval_queue_pkg::SIZE_RST;
      head_out_reg <= inval_queue_pkg::OFFSET_RST;
      empty_reg <= 1'b1;
      pend_reg <= 1'b0;
    end else begin
      base_out_reg <= {queue_base_reg, 12'h000} & base_mask;
      size_out_reg <= queue_size_reg;
      head_out_reg <= ptr_bus.head_offset;
      empty_reg <= ptr_bus.empty;
      pend_reg <= new_event;
    end
  end

  assign avs_readdata = rdata_reg;
  assign avs_waitrequest = waitreq_reg;
  assign queue_base_out = base_out_reg;
  assign queue_size_log2_out = size_out_reg;
  assign head_offset_out = head_out_reg;
  assign queue_empty_out = empty_reg;
  assign event_pending_out = pend_reg;
endmodule
`default_nettype wire

// ==== rtl/queue_head_ptr.sv ====
/*
  Head offset stepper of the invalidation queue. Advances one entry per
  fetch, wraps at the entry count given by the queue size.
  Ignores advance while the queue is empty, so head stops at tail.
*/
`timescale 1ns/10ps
`default_nettype none
module queue_head_ptr (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // Pointer carrier
  queue_ptr_if.ptr p
);
  logic [14:0] head_reg;
  logic [14:0] wrap_mask;
  logic [14:0] head_next;

  // Entry mask 2^(X+8)-1, offsets count 16-byte entries
  always_comb begin
    wrap_mask = 15'((32'd1 << (32'(p.size_log2) + inval_queue_pkg::ENTRY_SHIFT)) - 32'd1);
    head_next = (head_reg + 15'h0001) & wrap_mask;
  end

  // Head held at zero while disabled, else steps toward tail
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in || !p.enable) begin
      head_reg <= inval_queue_pkg::OFFSET_RST;
    end else if (p.advance && !p.empty) begin
      head_reg <= head_next;
    end
  end

  assign p.head_offset = head_reg;
  assign p.empty = (head_reg == p.tail_offset);
endmodule
`default_nettype wire

// ==== rtl/queue_ptr_if.sv ====
/*
  Carrier for the head pointer stepper: queue size, tail and head offsets.
  Assumes both ends on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
interface queue_ptr_if;
  logic [2:0] size_log2;
  logic [14:0] tail_offset;
  logic [14:0] head_offset;
  logic enable;
  logic advance;
  logic empty;
  modport regs (output size_log2, output tail_offset, output enable, output advance,
    input head_offset, input empty);
  modport ptr (input size_log2, input tail_offset, input enable, input advance,
    output head_offset, output empty);
endinterface
`default_nettype wire

// ==== rtl/wait_done_flag_cell.sv ====
/*
  Sticky wait-completion flag with write-one-to-clear and event detection.
  Assumes clear and set come from the same clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
module wait_done_flag_cell (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  // Controls
  input wire logic set_in,
  input wire logic clear_in,
  // State
  output logic flag_out,
  output logic new_event_out
);
  logic flag_reg;
  logic event_reg;

  // Set beats clear in the same cycle
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      flag_reg <= inval_queue_pkg::WAIT_DONE_RST;
    end else if (set_in) begin
      flag_reg <= 1'b1;
    end else if (clear_in) begin
      flag_reg <= 1'b0;
    end
  end

  // Event only when flag rises from clear
  always_ff @(posedge sys_clk_in) begin
    if (sys_rst_in) begin
      event_reg <= 1'b0;
    end else begin
      event_reg <= set_in && !flag_reg;
    end
  end

  assign flag_out = flag_reg;
  assign new_event_out = event_reg;
endmodule
`default_nettype wire

// ==== testbench/inval_queue_regs_sva.sv ====
/*
  Port checker for the invalidation queue register bank.
  Assumes one clock, a synchronous reset and binding to inval_queue_regs.
*/
`timescale 1ns/10ps
`default_nettype none
module inval_queue_regs_sva (
  // Clock, reset and bus
  input wire logic sys_clk_in,
  input wire logic sys_rst_in,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Fetch engine side
  input wire logic qi_supported_in,
  input wire logic fetch_in,
  input wire logic wait_done_in,
  input wire logic [63:0] queue_base_out,
  input wire logic [2:0] queue_size_log2_out,
  input wire logic [14:0] head_offset_out,
  input wire logic queue_empty_out,
  input wire logic event_pending_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (sys_rst_in);
  logic rd_ack;
  logic [14:0] wrap_mask;
  // Read answer and entry wrap mask
  assign rd_ack = avs_read && !avs_waitrequest;
  assign wrap_mask = 15'h7fff >> (3'h7 - queue_size_log2_out);
  property p_tail_lo;
    rd_ack && avs_address == 8'h88 |-> avs_readdata[3:0] == 4'h0 && avs_readdata[31:19] == 13'h0;
  endproperty
  a_tail_lo: assert property (p_tail_lo) else $error("tail reserved bits set");
  property p_tail_hi;
    rd_ack && avs_address == 8'h8c |-> avs_readdata == 32'h0000_0000;
  endproperty
  a_tail_hi: assert property (p_tail_hi) else $error("tail high word not zero");
  property p_addr_rsvd;
    rd_ack && avs_address == 8'h90 |-> avs_readdata[11:3] == 9'h0;
  endproperty
  a_addr_rsvd: assert property (p_addr_rsvd) else $error("address reserved bits set");
  property p_status_rsvd;
    rd_ack && avs_address == 8'h9c |-> avs_readdata[31:1] == 31'h0;
  endproperty
  a_status_rsvd: assert property (p_status_rsvd) else $error("status upper bits set");
  property p_nocap_zero;
    rd_ack && avs_address != 8'hc0 && !$past(qi_supported_in, 2)
      |-> avs_readdata == 32'h0000_0000;
  endproperty
  a_nocap_zero: assert property (p_nocap_zero) else $error("read without support not zero");
  property p_base_shape;
    queue_base_out[63:48] == 16'h0 && queue_base_out[11:0] == 12'h0;
  endproperty
  a_base_shape: assert property (p_base_shape) else $error("base out of shape");
  property p_event_cause;
    event_pending_out |-> $past(wait_done_in) || $past(wait_done_in, 2);
  endproperty
  a_event_cause: assert property (p_event_cause) else $error("event without wait");
  property p_event_once;
    event_pending_out |=> !event_pending_out;
  endproperty
  a_event_once: assert property (p_event_once) else $error("event repeated");
  property p_head_step;
    $changed(head_offset_out) |-> head_offset_out == 15'h0 ||
      head_offset_out == (($past(head_offset_out) + 15'h1) & wrap_mask);
  endproperty
  a_head_step: assert property (p_head_step) else $error("head step wrong");
  property p_head_cause;
    $changed(head_offset_out) |-> $past(fetch_in) || $past(fetch_in, 2) || head_offset_out == 15'h0;
  endproperty
  a_head_cause: assert property (p_head_cause) else $error("head moved alone");
endmodule
bind inval_queue_regs inval_queue_regs_sva inval_queue_regs_sva_inst (
  .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .qi_supported_in(qi_supported_in), .fetch_in(fetch_in),
  .wait_done_in(wait_done_in), .queue_base_out(queue_base_out),
  .queue_size_log2_out(queue_size_log2_out), .head_offset_out(head_offset_out),
  .queue_empty_out(queue_empty_out), .event_pending_out(event_pending_out));
`default_nettype wire

// ==== testbench/testbench.sv ====
/*
  Self-checking bench for the invalidation queue register bank.
  Assumes the package offsets, a 200 MHz clock and the bound port checker.
*/
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic sys_clk_in, sys_rst_in, avs_read, avs_write, avs_waitrequest;
  logic qi_supported_in, fetch_in, wait_done_in, queue_empty_out, event_pending_out;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, r, r2;
  logic [3:0] avs_byteenable;
  logic [63:0] queue_base_out;
  logic [2:0] queue_size_log2_out;
  logic [14:0] head_offset_out;
  logic [31:0] exp_q [$];
  logic [7:0] idle_map [7] = '{8'h88, 8'h8c, 8'h90, 8'h94, 8'h9c, 8'h84, 8'h10};
  int error_cnt, compares;
  inval_queue_regs inval_queue_regs_inst (
    .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .qi_supported_in(qi_supported_in),
    .fetch_in(fetch_in), .wait_done_in(wait_done_in), .queue_base_out(queue_base_out),
    .queue_size_log2_out(queue_size_log2_out), .head_offset_out(head_offset_out),
    .queue_empty_out(queue_empty_out), .event_pending_out(event_pending_out));
  // Free-running clock
  initial begin
    sys_clk_in = 1'b0;
    forever #2.5 sys_clk_in = ~sys_clk_in;
  end
  task chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task print_verdict();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // One bus transfer, held until waitrequest is sampled low
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    n = 0;
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n >= 20) begin
      error_cnt++;
      $display("wrong value at %0t: no bus answer", $time);
      print_verdict();
    end
    @(posedge sys_clk_in);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0000_0000);
  endtask
  task fetch(input int n);
    fetch_in <= 1'b1;
    repeat (n) @(posedge sys_clk_in);
    fetch_in <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
  endtask
  // One flagged wait completion, event pulses counted afterwards
  task pulse(input int want);
    int n;
    wait_done_in <= 1'b1;
    @(posedge sys_clk_in);
    wait_done_in <= 1'b0;
    n = 0;
    repeat (4) begin
      @(posedge sys_clk_in);
      n += (event_pending_out === 1'b1);
    end
    chk(n, want);
  endtask
  // Read answers compared against the oldest note
  always @(posedge sys_clk_in) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) chk(avs_readdata, exp_q.pop_front());
  end
  // Main sequence
  initial begin
    {sys_rst_in, qi_supported_in, avs_byteenable} = {2'b11, 4'hf};
    {avs_read, avs_write, fetch_in, wait_done_in} = 4'h0;
    {avs_address, avs_writedata} = 40'h0;
    error_cnt = 0;
    compares = 0;
    r = $urandom(32'ha380_aa7b);
    repeat (4) @(posedge sys_clk_in);
    sys_rst_in <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
    foreach (idle_map[i]) rd(idle_map[i], 32'h0000_0000);
    chk(queue_empty_out, 1'b1);
    $display("test reset values done");
    r = $urandom();
    wr(8'h88, r);
    rd(8'h88, r & 32'h0007_fff0);
    avs_byteenable <= 4'h1;
    wr(8'h88, ~r);
    avs_byteenable <= 4'hf;
    rd(8'h88, {r[31:8], ~r[7:0]} & 32'h0007_fff0);
    wr(8'h8c, r);
    rd(8'h8c, 32'h0000_0000);
    $display("test tail done");
    for (int x = 0; x < 8; x++) begin
      r = $urandom();
      wr(8'h90, {r[31:3], x[2:0]});
      rd(8'h90, {r[31:12], 9'h000, x[2:0]});
      chk(queue_size_log2_out, x[2:0]);
    end
    r2 = $urandom();
    wr(8'h94, r2);
    rd(8'h94, r2 & 32'h0000_ffff);
    chk(queue_base_out, {16'h0000, r2[15:0], r[31:12], 12'h000});
    $display("test address done");
    for (int x = 0; x < 8; x += 7) begin
      wr(8'h90, {r[31:12], 9'h000, x[2:0]});
      wr(8'hc0, 32'h0000_0000);
      wr(8'hc0, 32'h0000_0001);
      chk(head_offset_out, 15'h0000);
      rd(8'hc0, 32'h0000_0003);
      wr(8'h88, 32'h0000_0030);
      repeat (2) @(posedge sys_clk_in);
      chk(queue_empty_out, 1'b0);
      fetch(10);
      chk(head_offset_out, 15'h0003);
      wr(8'h88, 32'h0000_0010);
      fetch((1 << (x + 8)) - 2);
      chk(head_offset_out, 15'h0001);
      chk(queue_empty_out, 1'b1);
      rd(8'h80, 32'h0000_0010);
    end
    $display("test wrap done");
    pulse(1);
    pulse(0);
    rd(8'h9c, 32'h0000_0001);
    wr(8'h9c, 32'hffff_fffe);
    rd(8'h9c, 32'h0000_0001);
    wr(8'h9c, 32'h0000_0001);
    rd(8'h9c, 32'h0000_0000);
    pulse(1);
    $display("test status done");
    qi_supported_in <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
    foreach (idle_map[i]) rd(idle_map[i], 32'h0000_0000);
    rd(8'hc0, 32'h0000_0001);
    wr(8'h88, 32'h0000_0500);
    qi_supported_in <= 1'b1;
    repeat (2) @(posedge sys_clk_in);
    rd(8'h88, 32'h0000_0010);
    $display("test capability done");
    print_verdict();
  end
  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
endmodule
`default_nettype wire
